/* inc/accel_pkg.sv */
package accel_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_X_TRIM = 8'h1e;
  localparam logic [7:0] ADDR_Y_TRIM = 8'h1f;
  localparam logic [7:0] ADDR_Z_TRIM = 8'h20;
  localparam logic [7:0] ADDR_RATE = 8'h2c;
  localparam logic [7:0] ADDR_FORMAT = 8'h31;
  localparam logic [7:0] ADDR_X_LO = 8'h38;
  localparam logic [7:0] ADDR_X_HI = 8'h39;
  localparam logic [7:0] ADDR_Y_LO = 8'h3a;
  localparam logic [7:0] ADDR_Y_HI = 8'h3b;
  localparam logic [7:0] ADDR_Z_LO = 8'h3c;
  localparam logic [7:0] ADDR_Z_HI = 8'h3d;
  localparam logic [7:0] ADDR_STATUS = 8'h3e;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h0a;
  localparam logic [7:0] FORMAT_RESET = 8'h00;

  // ------------------------------------------------------------
  // fields
  // ------------------------------------------------------------
  localparam int unsigned FMT_SELF_TEST = 7;
  localparam int unsigned FMT_FULL_RES = 3;
  localparam int unsigned FMT_RANGE_LSB = 0;
  localparam int unsigned RATE_LSB = 0;
  localparam logic [3:0] RATE_FAST_MIN = 4'ha;
  localparam logic [1:0] RANGE_WIDEST = 2'h3;
  localparam int unsigned STAT_SETTLED = 0;
  localparam int unsigned STAT_SELF_TEST = 1;
  localparam int unsigned STAT_FAST_RATE = 2;

  // ------------------------------------------------------------
  // scaling and timing
  // ------------------------------------------------------------
  // one trim step is four full-resolution output steps
  localparam int unsigned TRIM_STEP_SHIFT = 2;
  localparam logic [2:0] ST_SETTLE_SAMPLES = 3'h4;
  localparam logic signed [15:0] SAMPLE_MAX = 16'sh7fff;
  localparam logic signed [15:0] SAMPLE_MIN = -16'sh8000;
  localparam logic signed [15:0] ONE_G_FULL_RES = 16'sh0200;
  localparam int unsigned AVG_SHIFT = 4;
  localparam logic [4:0] AVG_SAMPLES = 5'h10;
  localparam logic [7:0] FMT_MEASURE = 8'h0b;
  localparam logic [7:0] FMT_MEASURE_ST = 8'h8b;

  typedef logic signed [15:0] sample_t;
  typedef logic signed [7:0] trim_t;
  typedef logic signed [19:0] sum_t;

endpackage : accel_pkg

/* inc/accel_if.sv */
interface accel_if (
  input wire logic clk_i,
  input wire logic rst_i
);
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic data_ready;

  modport dev (
    input clk_i, rst_i, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid, data_ready
  );
  modport host (
    input clk_i, rst_i, reg_rdata, reg_rvalid, data_ready,
    output reg_wr, reg_rd, reg_addr, reg_wdata
  );
endinterface : accel_if

/* verilog/accel_trim_adder.sv */
module accel_trim_adder (
  // raw sample and trim
  input wire logic signed [15:0] sample_i,
  input wire logic signed [7:0] trim_i,
  // format
  input wire logic full_res_i,
  input wire logic [1:0] range_i,
  // compensated sample
  output logic signed [15:0] sum_o
);
  logic signed [15:0] weight;
  logic signed [16:0] wide;

  always_comb begin
    weight = 16'(trim_i) <<< accel_pkg::TRIM_STEP_SHIFT; // [RULE9]
    // fixed resolution: output step grows with range, trim weight stays [RULE2]
    if (!full_res_i) begin
      weight = weight >>> range_i;
    end
    wide = 17'(sample_i) + 17'(weight); // [RULE1]
    // saturate instead of wrapping near full scale
    if (wide > 17'(accel_pkg::SAMPLE_MAX)) begin
      sum_o = accel_pkg::SAMPLE_MAX;
    end else if (wide < 17'(accel_pkg::SAMPLE_MIN)) begin
      sum_o = accel_pkg::SAMPLE_MIN;
    end else begin
      sum_o = wide[15:0];
    end
  end
endmodule : accel_trim_adder

/* verilog/accel_dev.sv */
// How it works
// RULE1: signed per-axis trim added to every sample
// RULE2: trim step fixed weight, any range
// RULE3: trims read zero after power-up reset
// RULE4: rate field low nibble; 0x0A up fast
// RULE5: full-res plus range 3 gives widest range
// RULE6: format bit 7 set drives self-test stimulus
// RULE7: format bit 7 clear removes stimulus
// RULE8: about four samples settle after self-test on
// RULE9: full-res trim step equals four outputs
// RULE10: host writes negated rounded offset as trim
// RULE11: host averages enough samples when calibrating
// RULE12: host self-test: off, on, settle, on, off
// RULE13: host change equals on average minus off
module accel_dev (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  accel_if.dev bus,
  // sensing element samples
  input wire logic sample_valid_i,
  input wire logic signed [15:0] sample_x_i,
  input wire logic signed [15:0] sample_y_i,
  input wire logic signed [15:0] sample_z_i,
  // controls to the sensing front end
  output logic self_test_o,
  output logic [3:0] rate_code_o,
  output logic fast_rate_o,
  output logic full_res_o,
  output logic [1:0] range_o,
  output logic widest_range_o,
  output logic st_settled_o,
  // compensated data
  output logic signed [15:0] data_x_o,
  output logic signed [15:0] data_y_o,
  output logic signed [15:0] data_z_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0] trim;
    logic [7:0] rate;
    logic [7:0] fmt;
    logic [2:0][15:0] data;
    logic [2:0] settle;
    logic [7:0] rdata;
    logic rvalid;
    logic drdy;
  } dev_state_t;

  dev_state_t st;
  dev_state_t next_st;

  logic [2:0][15:0] raw;
  logic [2:0][15:0] comp;
  logic st_on;
  logic full_res;
  logic [1:0] range_sel;

  assign raw[0] = sample_x_i;
  assign raw[1] = sample_y_i;
  assign raw[2] = sample_z_i;

  assign st_on = st.fmt[accel_pkg::FMT_SELF_TEST];
  assign full_res = st.fmt[accel_pkg::FMT_FULL_RES];
  assign range_sel = st.fmt[accel_pkg::FMT_RANGE_LSB +: 2];

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
    byte_of = hi ? w[15:8] : w[7:0];
  endfunction : byte_of

  function automatic logic fast_code(input logic [7:0] r);
    fast_code = r[accel_pkg::RATE_LSB +: 4] >= accel_pkg::RATE_FAST_MIN;
  endfunction : fast_code

  function automatic logic settled(input dev_state_t s);
    settled = s.fmt[accel_pkg::FMT_SELF_TEST] &&
              (s.settle == accel_pkg::ST_SETTLE_SAMPLES);
  endfunction : settled

  function automatic logic [7:0] read_mux(input dev_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = accel_pkg::READ_UNMAPPED;
    case (a)
      accel_pkg::ADDR_X_TRIM: v = s.trim[0];
      accel_pkg::ADDR_Y_TRIM: v = s.trim[1];
      accel_pkg::ADDR_Z_TRIM: v = s.trim[2];
      accel_pkg::ADDR_RATE: v = s.rate;
      accel_pkg::ADDR_FORMAT: v = s.fmt;
      accel_pkg::ADDR_X_LO: v = byte_of(s.data[0], 1'b0);
      accel_pkg::ADDR_X_HI: v = byte_of(s.data[0], 1'b1);
      accel_pkg::ADDR_Y_LO: v = byte_of(s.data[1], 1'b0);
      accel_pkg::ADDR_Y_HI: v = byte_of(s.data[1], 1'b1);
      accel_pkg::ADDR_Z_LO: v = byte_of(s.data[2], 1'b0);
      accel_pkg::ADDR_Z_HI: v = byte_of(s.data[2], 1'b1);
      accel_pkg::ADDR_STATUS: begin
        v[accel_pkg::STAT_SETTLED] = settled(s);
        v[accel_pkg::STAT_SELF_TEST] = s.fmt[accel_pkg::FMT_SELF_TEST];
        v[accel_pkg::STAT_FAST_RATE] = fast_code(s.rate);
      end
      default: v = accel_pkg::READ_UNMAPPED;
    endcase
    return v;
  endfunction : read_mux

  // ------------------------------------------------------------
  // per-axis compensation
  // ------------------------------------------------------------
  // one adder per axis; all three share the format in force
  for (genvar i = 0; i < 3; i++) begin : g_axis
    accel_trim_adder u_add (
      .sample_i(raw[i]),
      .trim_i(st.trim[i]),
      .full_res_i(full_res),
      .range_i(range_sel),
      .sum_o(comp[i])
    ); // [RULE1] [RULE2]
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.drdy = 1'b0;

    // no byte latching: a sample landing between a lo and a hi read
    // mixes halves, so the reader must fetch right after data_ready
    if (bus.reg_rd) begin
      next_st.rdata = read_mux(st, bus.reg_addr);
      next_st.rvalid = 1'b1;
    end

    // a new sample always lands the trims and format in force this cycle
    if (sample_valid_i) begin
      next_st.data = comp; // [RULE1]
      next_st.drdy = 1'b1;
      if (st_on && (st.settle != accel_pkg::ST_SETTLE_SAMPLES)) begin
        next_st.settle = st.settle + 3'h1; // [RULE8]
      end
    end

    // data, status and unmapped addresses ignore writes
    if (bus.reg_wr) begin
      case (bus.reg_addr)
        accel_pkg::ADDR_X_TRIM: next_st.trim[0] = bus.reg_wdata;
        accel_pkg::ADDR_Y_TRIM: next_st.trim[1] = bus.reg_wdata;
        accel_pkg::ADDR_Z_TRIM: next_st.trim[2] = bus.reg_wdata;
        accel_pkg::ADDR_RATE: next_st.rate = bus.reg_wdata; // [RULE4]
        accel_pkg::ADDR_FORMAT: begin
          next_st.fmt = bus.reg_wdata; // [RULE5] [RULE6] [RULE7]
          // settling restarts on every off-to-on edge of self-test
          if (!bus.reg_wdata[accel_pkg::FMT_SELF_TEST] || !st_on) begin
            next_st.settle = '0; // [RULE8]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // trims are volatile: every power-up reset brings them back to zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.trim <= {3{accel_pkg::TRIM_RESET}}; // [RULE3]
      st.rate <= accel_pkg::RATE_RESET;
      st.fmt <= accel_pkg::FORMAT_RESET;
      st.data <= '0;
      st.settle <= '0;
      st.rdata <= '0;
      st.rvalid <= 1'b0;
      st.drdy <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus.reg_rdata = st.rdata;
  assign bus.reg_rvalid = st.rvalid;
  assign bus.data_ready = st.drdy;

  assign self_test_o = st_on; // [RULE6] [RULE7]
  assign rate_code_o = st.rate[accel_pkg::RATE_LSB +: 4];
  assign fast_rate_o = fast_code(st.rate); // [RULE4]
  assign full_res_o = full_res;
  assign range_o = range_sel;
  assign widest_range_o = full_res && (range_sel == accel_pkg::RANGE_WIDEST); // [RULE5]
  assign st_settled_o = settled(st); // [RULE8]

  assign data_x_o = st.data[0];
  assign data_y_o = st.data[1];
  assign data_z_o = st.data[2];

endmodule : accel_dev

/* verilog/accel_host.sv */
module accel_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  accel_if.host bus,
  // commands
  input wire logic cal_start_i,
  input wire logic st_start_i,
  // results
  output logic busy_o,
  output logic done_o,
  output logic signed [7:0] trim_x_o,
  output logic signed [7:0] trim_y_o,
  output logic signed [7:0] trim_z_o,
  output logic signed [15:0] st_dx_o,
  output logic signed [15:0] st_dy_o,
  output logic signed [15:0] st_dz_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_STEP, S_WAIT, S_READ, S_SUM} phase_t;
  typedef enum logic [1:0] {OP_WR, OP_MEAS, OP_SKIP, OP_DONE} op_t;

  typedef struct packed {
    phase_t phase;
    logic mode_st;
    logic [3:0] pc;
    logic [2:0] ridx;
    logic [2:0] cidx;
    logic [5:0][7:0] bytes;
    logic [2:0][19:0] sum;
    logic [4:0] cnt;
    logic [2:0][15:0] off_avg;
    logic [2:0][7:0] trim;
    logic [2:0][15:0] delta;
    logic done;
  } host_state_t;

  host_state_t st;
  host_state_t next_st;
  op_t op;
  logic [7:0] op_addr;
  logic [7:0] op_data;

  function automatic logic signed [15:0] avg_of(input logic signed [19:0] s);
    avg_of = 16'(s >>> accel_pkg::AVG_SHIFT);
  endfunction : avg_of

  // negated offset rounded to the nearest trim step
  function automatic logic [7:0] trim_of(input logic signed [15:0] a);
    logic signed [15:0] r;
    r = (a + 16'sh0002) >>> accel_pkg::TRIM_STEP_SHIFT;
    trim_of = 8'(-r); // [RULE10]
  endfunction : trim_of

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  always_comb begin
    op = OP_DONE;
    op_addr = accel_pkg::ADDR_RATE;
    op_data = 8'(accel_pkg::RATE_FAST_MIN);
    case ({st.mode_st, st.pc})
      5'h00, 5'h10: op = OP_WR;
      5'h01, 5'h11: begin
        op = OP_WR;
        op_addr = accel_pkg::ADDR_FORMAT;
        op_data = accel_pkg::FMT_MEASURE;
      end
      5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08: begin
        op = OP_WR;
        op_addr = (st.pc < 4'h5) ? accel_pkg::ADDR_X_TRIM + 8'(st.pc - 4'h2)
                                 : accel_pkg::ADDR_X_TRIM + 8'(st.pc - 4'h6);
        op_data = (st.pc < 4'h5) ? accel_pkg::TRIM_RESET : st.trim[st.pc - 4'h6];
      end
      5'h05, 5'h12, 5'h15: op = OP_MEAS; // [RULE11]
      5'h13, 5'h16: begin
        op = OP_WR;
        op_addr = accel_pkg::ADDR_FORMAT;
        op_data = (st.pc == 4'h3) ? accel_pkg::FMT_MEASURE_ST : accel_pkg::FMT_MEASURE;
      end // [RULE12]
      5'h14: op = OP_SKIP; // [RULE12]
      default: op = OP_DONE;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (bus.reg_rvalid && st.phase == S_READ) begin
      next_st.bytes[st.cidx] = bus.reg_rdata;
      next_st.cidx = st.cidx + 3'h1;
    end
    case (st.phase)
      S_IDLE: begin
        if (cal_start_i || st_start_i) begin
          next_st.mode_st = st_start_i && !cal_start_i;
          next_st.pc = '0;
          next_st.phase = S_STEP;
        end
      end
      S_STEP: begin
        next_st.cnt = '0;
        next_st.sum = '0;
        case (op)
          OP_WR: next_st.pc = st.pc + 4'h1;
          OP_MEAS, OP_SKIP: next_st.phase = S_WAIT;
          default: begin
            next_st.phase = S_IDLE;
            next_st.done = 1'b1;
          end
        endcase
      end
      S_WAIT: begin
        if (bus.data_ready) begin
          if (op == OP_SKIP) begin
            next_st.cnt = st.cnt + 5'h1;
            if (st.cnt == 5'(accel_pkg::ST_SETTLE_SAMPLES - 3'h1)) begin
              next_st.pc = st.pc + 4'h1;
              next_st.phase = S_STEP;
            end
          end else begin
            next_st.ridx = '0;
            next_st.cidx = '0;
            next_st.phase = S_READ;
          end
        end
      end
      S_READ: begin
        if (st.ridx != 3'h6) begin
          next_st.ridx = st.ridx + 3'h1;
        end
        if (bus.reg_rvalid && st.cidx == 3'h5) begin
          next_st.phase = S_SUM;
        end
      end
      S_SUM: begin
        for (int i = 0; i < 3; i++) begin
          next_st.sum[i] = st.sum[i] + 20'($signed({st.bytes[2 * i + 1], st.bytes[2 * i]}));
        end
        next_st.cnt = st.cnt + 5'h1;
        next_st.phase = S_WAIT;
        if (st.cnt == accel_pkg::AVG_SAMPLES - 5'h1) begin
          next_st.phase = S_STEP;
          next_st.pc = st.pc + 4'h1;
          for (int i = 0; i < 3; i++) begin
            if (!st.mode_st) begin
              next_st.trim[i] = trim_of(avg_of(next_st.sum[i]) -
                                ((i == 2) ? accel_pkg::ONE_G_FULL_RES : 16'sh0000));
            end else if (st.pc == 4'h2) begin
              next_st.off_avg[i] = avg_of(next_st.sum[i]);
            end else begin
              next_st.delta[i] = avg_of(next_st.sum[i]) - st.off_avg[i]; // [RULE13]
            end
          end
        end
      end
      default: next_st.phase = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus.reg_wr = (st.phase == S_STEP) && (op == OP_WR);
  assign bus.reg_rd = (st.phase == S_READ) && (st.ridx != 3'h6);
  assign bus.reg_addr = (st.phase == S_READ) ? accel_pkg::ADDR_X_LO + 8'(st.ridx) : op_addr;
  assign bus.reg_wdata = op_data;
  assign busy_o = st.phase != S_IDLE;
  assign done_o = st.done;
  assign trim_x_o = st.trim[0];
  assign trim_y_o = st.trim[1];
  assign trim_z_o = st.trim[2];
  assign st_dx_o = st.delta[0];
  assign st_dy_o = st.delta[1];
  assign st_dz_o = st.delta[2];

endmodule : accel_host

/* tb/accel_offset_selftest_ctrl_checker.sv */
module accel_offset_selftest_ctrl_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic data_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // 4 settle samples plus 16 averaged
  localparam int ST_MIN = 20;
  logic st_on;
  logic [7:0] on_cnt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // --------------------------------------------------------------
  // self-test sample count seen on the bus
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_on <= 1'b0;
      on_cnt <= 8'h00;
    end else if (reg_wr && reg_addr == accel_pkg::ADDR_FORMAT) begin
      st_on <= reg_wdata[accel_pkg::FMT_SELF_TEST];
      if (reg_wdata[accel_pkg::FMT_SELF_TEST] && !st_on) begin
        on_cnt <= 8'h00;
      end
    end else if (data_ready && st_on && on_cnt != 8'hff) begin
      on_cnt <= on_cnt + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  rate_fast_a: assert property (reg_wr && reg_addr == accel_pkg::ADDR_RATE
    |-> reg_wdata[3:0] >= accel_pkg::RATE_FAST_MIN) else $error("slow rate written");
  range_widest_a: assert property (reg_wr && reg_addr == accel_pkg::ADDR_FORMAT
    |-> reg_wdata[3] && reg_wdata[1:0] == accel_pkg::RANGE_WIDEST)
    else $error("format not widest full resolution");
  rate_format_a: assert property (reg_wr && reg_addr == accel_pkg::ADDR_RATE
    |=> reg_wr && reg_addr == accel_pkg::ADDR_FORMAT) else $error("format not after rate");
  settle_wait_a: assert property (reg_wr && reg_addr == accel_pkg::ADDR_FORMAT
    && !reg_wdata[7] && st_on |-> on_cnt >= ST_MIN) else $error("self-test left too early");
  data_read_a: assert property (reg_rd |-> reg_addr >= accel_pkg::ADDR_X_LO
    && reg_addr <= accel_pkg::ADDR_Z_HI) else $error("host read outside data");
endmodule : accel_offset_selftest_ctrl_checker

/* tb/test_accel_offset_selftest_ctrl.sv */
module test_accel_offset_selftest_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, sv, cal, stt, st_a, st_b, fast_b, wide_b, set_b, busy, done, auto_on;
  logic signed [15:0] sx, sy, sz, db_x, db_y, db_z, da_x, da_y, da_z, st_dx, st_dy, st_dz;
  logic signed [7:0] tx, ty, tz;
  logic [3:0] rate_b;
  logic full_b;
  logic [1:0] range_b;
  logic [7:0] fmt;
  logic [15:0] e;
  int err_count, check_count, seed, rx, ry, rz, shift, raw, trim;

  accel_if bus_a (.clk_i(clk_i), .rst_i(rst_i));
  accel_if bus_b (.clk_i(clk_i), .rst_i(rst_i));
  accel_dev u_accel_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_a), .sample_valid_i(sv),
    .sample_x_i(sx), .sample_y_i(sy), .sample_z_i(sz), .self_test_o(st_a), .rate_code_o(),
    .fast_rate_o(), .full_res_o(), .range_o(), .widest_range_o(), .st_settled_o(),
    .data_x_o(da_x), .data_y_o(da_y), .data_z_o(da_z));
  // second device, driven directly by the bench to reach every register but the Y and Z data bytes
  accel_dev u_accel_dev_b (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_b), .sample_valid_i(sv),
    .sample_x_i(sx), .sample_y_i(sy), .sample_z_i(sz), .self_test_o(st_b),
    .rate_code_o(rate_b), .fast_rate_o(fast_b), .full_res_o(full_b), .range_o(range_b),
    .widest_range_o(wide_b), .st_settled_o(set_b), .data_x_o(db_x), .data_y_o(db_y),
    .data_z_o(db_z));
  accel_host u_accel_host (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_a), .cal_start_i(cal),
    .st_start_i(stt), .busy_o(busy), .done_o(done), .trim_x_o(tx), .trim_y_o(ty),
    .trim_z_o(tz), .st_dx_o(st_dx), .st_dy_o(st_dy), .st_dz_o(st_dz));
  accel_offset_selftest_ctrl_checker u_accel_offset_selftest_ctrl_checker (.clk_i(clk_i),
    .rst_i(rst_i), .reg_wr(bus_a.reg_wr), .reg_rd(bus_a.reg_rd), .reg_addr(bus_a.reg_addr),
    .reg_wdata(bus_a.reg_wdata), .reg_rdata(bus_a.reg_rdata),
    .reg_rvalid(bus_a.reg_rvalid), .data_ready(bus_a.data_ready));

  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------
  // checks and expectations
  // --------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] comp(input int r, input int t, input logic [7:0] f);
    int s;
    s = t * 4;
    if (!f[3]) s = s >>> f[1:0];
    s = s + r;
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return s[15:0];
  endfunction : comp

  function automatic logic [15:0] tr(input int avg);
    int t;
    t = -((avg + 2) >>> 2);
    return {{8{t[7]}}, t[7:0]};
  endfunction : tr

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2 bus_b.reg_wr = 1;
    bus_b.reg_addr = a;
    bus_b.reg_wdata = d;
    @(posedge clk_i);
    #2 bus_b.reg_wr = 0;
  endtask : wr

  task rdck(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #2 bus_b.reg_rd = 1;
    bus_b.reg_addr = a;
    @(posedge clk_i);
    #2 bus_b.reg_rd = 0;
    chk(bus_b.reg_rvalid, 1);
    chk(bus_b.reg_rdata, exp);
  endtask : rdck

  task samp(input int x, input int y, input int z);
    @(posedge clk_i);
    #2 sv = 1;
    sx = 16'(x);
    sy = 16'(y);
    sz = 16'(z);
    @(posedge clk_i);
    #2 sv = 0;
    chk(bus_b.data_ready, 1);
  endtask : samp

  task host_run(input logic st);
    @(posedge clk_i);
    #2 if (st) stt = 1; else cal = 1;
    @(posedge clk_i);
    #2 stt = 0;
    cal = 0;
    chk(busy, 1);
    for (int i = 0; i < 4000 && done !== 1'b1; i++) @(posedge clk_i) #1;
    chk(done, 1);
    chk(busy, 0);
  endtask : host_run

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // sensing element stand-in: self-test shifts what it reports
  initial forever begin
    repeat (32) @(posedge clk_i);
    if (auto_on) begin
      #2 sx = 16'(rx + (st_a ? shift : 0));
      sy = 16'(ry - (st_a ? shift : 0));
      sz = 16'(rz + (st_a ? shift / 2 : 0));
      sv = 1;
      @(posedge clk_i);
      #2 sv = 0;
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    wrap_up();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'h9262;
    {rst_i, sv, cal, stt, auto_on, sx, sy, sz} = {1'b1, 52'h0};
    {bus_b.reg_wr, bus_b.reg_rd, bus_b.reg_addr, bus_b.reg_wdata} = 18'h0;
    repeat (16) @(posedge clk_i);
    #2 rst_i = 0;
    rdck(accel_pkg::ADDR_X_TRIM, accel_pkg::TRIM_RESET);
    rdck(accel_pkg::ADDR_Y_TRIM, accel_pkg::TRIM_RESET);
    rdck(accel_pkg::ADDR_Z_TRIM, accel_pkg::TRIM_RESET);
    rdck(accel_pkg::ADDR_RATE, accel_pkg::RATE_RESET);
    rdck(accel_pkg::ADDR_FORMAT, accel_pkg::FORMAT_RESET);
    wr(8'h25, 8'h5a);
    rdck(8'h25, accel_pkg::READ_UNMAPPED);
    $display("test reset values done");
    for (int c = 0; c < 16; c++) begin
      wr(accel_pkg::ADDR_RATE, c[7:0]);
      chk(fast_b, c >= 10);
      chk(rate_b, c[3:0]);
    end
    $display("test rate codes done");
    for (int f = 0; f < 8; f++) begin
      fmt = {4'h0, f[2], 1'b0, f[1:0]};
      trim = $random(seed) % 128;
      raw = $random(seed) % 30000;
      if (f == 7) {raw, trim} = {32'sd32700, 32'sd127};
      if (f == 6) {raw, trim} = {-32'sd32700, -32'sd128};
      wr(accel_pkg::ADDR_FORMAT, fmt);
      wr(accel_pkg::ADDR_X_TRIM, trim[7:0]);
      wr(accel_pkg::ADDR_Y_TRIM, 8'(trim / 2));
      wr(accel_pkg::ADDR_Z_TRIM, 8'hff);
      rdck(accel_pkg::ADDR_X_TRIM, trim[7:0]);
      samp(raw, -raw, raw);
      e = comp(raw, trim, fmt);
      chk(db_x, e);
      chk(db_y, comp(-raw, trim / 2, fmt));
      chk(db_z, comp(raw, -1, fmt));
      chk(wide_b, f == 7);
      chk(full_b, f[2]);
      chk(range_b, f[1:0]);
      rdck(accel_pkg::ADDR_X_LO, e[7:0]);
      rdck(accel_pkg::ADDR_X_HI, e[15:8]);
    end
    $display("test trim and formats done");
    wr(accel_pkg::ADDR_FORMAT, accel_pkg::FMT_MEASURE_ST);
    chk(st_b, 1);
    for (int i = 1; i <= 5; i++) begin
      samp(0, 0, 0);
      chk(set_b, i >= 4);
      fmt = 8'((1 << accel_pkg::STAT_SELF_TEST) | (1 << accel_pkg::STAT_FAST_RATE));
      fmt[accel_pkg::STAT_SETTLED] = i >= 4;
      rdck(accel_pkg::ADDR_STATUS, fmt);
    end
    wr(accel_pkg::ADDR_FORMAT, accel_pkg::FMT_MEASURE);
    chk(st_b, 0);
    chk(set_b, 0);
    $display("test self-test settle done");
    auto_on = 1;
    for (int k = 0; k < 2; k++) begin
      rx = k ? $random(seed) % 300 : 10;
      ry = k ? $random(seed) % 300 : -13;
      rz = k ? 512 + $random(seed) % 300 : 521;
      host_run(0);
      chk(tx, tr(rx));
      chk(ty, tr(ry));
      chk(tz, tr(rz - 512));
      repeat (40) @(posedge clk_i);
      #2 chk(da_x, comp(rx, $signed(tr(rx)), accel_pkg::FMT_MEASURE));
    end
    $display("test host calibration done");
    shift = 100 + ($random(seed) & 255);
    host_run(1);
    chk(st_dx, 16'(shift));
    chk(st_dy, 16'(-shift));
    chk(st_dz, 16'(shift / 2));
    chk(st_a, 0);
    $display("test host self-test done");
    auto_on = 0;
    wr(accel_pkg::ADDR_X_TRIM, 8'h33);
    rdck(accel_pkg::ADDR_X_TRIM, 8'h33);
    #2 rst_i = 1;
    repeat (2) @(posedge clk_i);
    #2 rst_i = 0;
    rdck(accel_pkg::ADDR_X_TRIM, accel_pkg::TRIM_RESET);
    $display("test second reset done");
    wrap_up();
  end
endmodule : test_accel_offset_selftest_ctrl
